// file: include/suc_pkg.sv
// shared constants for the 4-bit up/down counter block
// assumes one 40 MHz clock and a classic wishbone register port
package suc_pkg;

   // ****************************************
   // widths
   // ****************************************
   localparam int SUC_CW = 4;
   localparam int SUC_DW = 32;
   localparam int SUC_AW = 4;
   localparam int SUC_CTRL_W = 8;

   // ****************************************
   // register offsets (byte addresses)
   // ****************************************
   localparam logic [SUC_AW-1:0] SUC_OFS_CTRL = 4'h0;
   localparam logic [SUC_AW-1:0] SUC_OFS_STAT = 4'h4;

   // ****************************************
   // control register fields
   // ****************************************
   localparam int SUC_CTRL_UP = 0;
   localparam int SUC_CTRL_P_N = 1;
   localparam int SUC_CTRL_T_N = 2;
   localparam int SUC_CTRL_LOAD_N = 3;
   localparam int SUC_CTRL_PRE_LSB = 4;

   // ****************************************
   // status register fields
   // ****************************************
   localparam int SUC_STAT_CNT_LSB = 0;
   localparam int SUC_STAT_CARRY_N = 4;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [SUC_CTRL_W-1:0] SUC_CTRL_RST = 8'h0e;
   localparam logic [SUC_CW-1:0] SUC_CNT_RST = 4'h0;
   localparam logic SUC_CARRY_N_RST = 1'b1;
   localparam logic SUC_ACK_RST = 1'b0;
   localparam logic [SUC_DW-1:0] SUC_DAT_RST = 32'h0000_0000;

   // terminal count: all ones going up, all zeros going down
   function automatic logic suc_terminal(input logic [SUC_CW-1:0] cnt, input logic up);
      return up ? (&cnt) : ~(|cnt);
   endfunction

endpackage

// file: logic/suc_count_core.sv
// next-state logic of the 4-bit synchronous up/down counter
// assumes the caller registers the result on the rising clock edge
`timescale 1ns/100ps
module suc_count_core #(
   parameter int W = suc_pkg::SUC_CW
) (
   input wire logic [W-1:0] cnt_i,     // present count
   input wire logic [W-1:0] preset_i,  // parallel preset data
   input wire logic load_n_i,          // load, active low
   input wire logic p_n_i,             // count enable p, active low
   input wire logic t_n_i,             // count enable t, active low
   input wire logic up_i,              // 1 counts up, 0 counts down
   output logic [W-1:0] cnt_nxt_o      // count after the next edge
);
   import suc_pkg::*;

   // ****************************************
   // next count
   // ****************************************
   always_comb begin
      cnt_nxt_o = cnt_i;
      if (!load_n_i) begin
         cnt_nxt_o = preset_i;
      end else if (!p_n_i && !t_n_i) begin
         cnt_nxt_o = up_i ? cnt_i + W'(1) : cnt_i - W'(1);
      end
   end

endmodule

// file: logic/suc_wb_slave.sv
// classic wishbone slave for the counter's two registers
// assumes a master that holds its request until ack, one access at a time
`timescale 1ns/100ps
module suc_wb_slave (
   input wire logic clk_i,                             // system clock
   input wire logic rst_i,                             // sync reset, high
   input wire logic cyc_i,                             // bus cycle
   input wire logic stb_i,                             // strobe
   input wire logic we_i,                              // write enable
   input wire logic [suc_pkg::SUC_AW-1:0] adr_i,       // byte address
   input wire logic [3:0] sel_i,                       // byte selects
   input wire logic [suc_pkg::SUC_DW-1:0] dat_i,       // write data
   input wire logic [suc_pkg::SUC_CTRL_W-1:0] ctrl_i,  // control readback
   input wire logic [suc_pkg::SUC_CTRL_W-1:0] stat_i,  // status readback
   output logic [suc_pkg::SUC_DW-1:0] dat_o,           // read data
   output logic ack_o,                                 // ack, one cycle
   output logic wr_ctrl_o,                             // control write pulse
   output logic [suc_pkg::SUC_CTRL_W-1:0] wr_data_o    // control write data
);
   import suc_pkg::*;

   logic req;

   assign req = cyc_i & stb_i;

   // ****************************************
   // acknowledge: one cycle after the request
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= SUC_ACK_RST;
      end else begin
         ack_o <= req & ~ack_o;
      end
   end

   // ****************************************
   // read data, captured with the request
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= SUC_DAT_RST;
      end else if (req && !ack_o && !we_i) begin
         unique case (adr_i)
            SUC_OFS_CTRL: dat_o <= {{(SUC_DW-SUC_CTRL_W){1'b0}}, ctrl_i};
            SUC_OFS_STAT: dat_o <= {{(SUC_DW-SUC_CTRL_W){1'b0}}, stat_i};
            default: dat_o <= SUC_DAT_RST;
         endcase
      end
   end

   // write lands on the edge where ack is seen high
   assign wr_ctrl_o = req & we_i & ack_o & sel_i[0] & (adr_i == SUC_OFS_CTRL);
   assign wr_data_o = dat_i[SUC_CTRL_W-1:0];

endmodule

// file: logic/suc_top.sv
// top of the 4-bit synchronous up/down presettable counter
// assumes one clock, synchronous inputs and a classic wishbone master
`timescale 1ns/100ps
module suc_top (
   input wire logic clk_i,                          // 40 MHz clock
   input wire logic rst_i,                          // sync reset, high
   input wire logic cyc_i,                          // wishbone cycle
   input wire logic stb_i,                          // wishbone strobe
   input wire logic we_i,                           // wishbone write
   input wire logic [suc_pkg::SUC_AW-1:0] adr_i,    // wishbone address
   input wire logic [3:0] sel_i,                    // wishbone selects
   input wire logic [suc_pkg::SUC_DW-1:0] dat_i,    // wishbone write data
   input wire logic ext_p_n_i,                      // cascade enable p, low
   input wire logic ext_t_n_i,                      // cascade enable t, low
   input wire logic ext_load_n_i,                   // cascade load, low
   output logic [suc_pkg::SUC_DW-1:0] dat_o,        // wishbone read data
   output logic ack_o,                              // wishbone ack
   output logic [suc_pkg::SUC_CW-1:0] count_outputs_o, // count value
   output logic carry_n_o                           // carry, active low
);
   import suc_pkg::*;

   // ****************************************
   // declarations
   // ****************************************
   logic [SUC_CTRL_W-1:0] ctrl_r;
   logic [SUC_CTRL_W-1:0] ctrl_nxt;
   logic [SUC_CTRL_W-1:0] stat;
   logic [SUC_CTRL_W-1:0] wr_data;
   logic wr_ctrl;
   logic [SUC_CW-1:0] cnt_r;
   logic [SUC_CW-1:0] cnt_nxt;
   logic carry_n_r;
   logic carry_n_nxt;
   logic load_eff_n;
   logic p_eff_n;
   logic t_eff_n;
   logic t_fwd_n;
   logic up_eff;
   logic [SUC_CW-1:0] preset;

   // ****************************************
   // register port
   // ****************************************
   suc_wb_slave u_wb (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cyc_i(cyc_i),
      .stb_i(stb_i),
      .we_i(we_i),
      .adr_i(adr_i),
      .sel_i(sel_i),
      .dat_i(dat_i),
      .ctrl_i(ctrl_r),
      .stat_i(stat),
      .dat_o(dat_o),
      .ack_o(ack_o),
      .wr_ctrl_o(wr_ctrl),
      .wr_data_o(wr_data)
   );

   assign stat = {{(SUC_CTRL_W-SUC_CW-1){1'b0}}, carry_n_r, cnt_r};

   // ****************************************
   // control register
   // ****************************************
   assign ctrl_nxt = wr_ctrl ? wr_data : ctrl_r;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_r <= SUC_CTRL_RST;
      end else begin
         ctrl_r <= ctrl_nxt;
      end
   end

   // ****************************************
   // effective controls: register and cascade pins
   // ****************************************
   // a low on either source asserts load, so a neighbour's carry can load
   assign load_eff_n = ctrl_r[SUC_CTRL_LOAD_N] & ext_load_n_i;
   // enables are low only when both sources are low, for chaining
   assign p_eff_n = ctrl_r[SUC_CTRL_P_N] | ext_p_n_i;
   assign t_eff_n = ctrl_r[SUC_CTRL_T_N] | ext_t_n_i;
   assign up_eff = ctrl_r[SUC_CTRL_UP];
   assign preset = ctrl_r[SUC_CTRL_PRE_LSB +: SUC_CW];

   // ****************************************
   // count state
   // ****************************************
   suc_count_core #(
      .W(SUC_CW)
   ) u_core (
      .cnt_i(cnt_r),
      .preset_i(preset),
      .load_n_i(load_eff_n),
      .p_n_i(p_eff_n),
      .t_n_i(t_eff_n),
      .up_i(up_eff),
      .cnt_nxt_o(cnt_nxt)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_r <= SUC_CNT_RST;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   // ****************************************
   // carry look-ahead
   // ****************************************
   // carry is judged on the state after this edge so the flop shows it
   // in the same cycle as the count it belongs to
   assign t_fwd_n = ctrl_nxt[SUC_CTRL_T_N] | ext_t_n_i;
   assign carry_n_nxt = ~(~t_fwd_n & suc_terminal(cnt_nxt, ctrl_nxt[SUC_CTRL_UP]));

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         carry_n_r <= SUC_CARRY_N_RST;
      end else begin
         carry_n_r <= carry_n_nxt;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign count_outputs_o = cnt_r;
   assign carry_n_o = carry_n_r;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   chk_load_preset: assert property (
      !load_eff_n |=> cnt_r == $past(preset))
      else $error("load did not take the preset data");

   chk_count_up_one: assert property (
      (load_eff_n && !p_eff_n && !t_eff_n && up_eff)
      |=> cnt_r == $past(cnt_r) + 4'h1)
      else $error("up count did not advance by one");

   chk_count_down_one: assert property (
      (load_eff_n && !p_eff_n && !t_eff_n && !up_eff)
      |=> cnt_r == $past(cnt_r) - 4'h1)
      else $error("down count did not fall by one");

   chk_hold_disabled: assert property (
      (load_eff_n && (p_eff_n || t_eff_n)) |=> $stable(cnt_r))
      else $error("count moved while disabled");

   chk_advance_cause: assert property (
      (cnt_r != $past(cnt_r)) && !$past(rst_i)
      |-> $past(!load_eff_n || (!p_eff_n && !t_eff_n)))
      else $error("count changed without load or both enables");

   chk_carry_gated_t: assert property (
      !carry_n_r && !$past(rst_i)
      |-> !ctrl_r[SUC_CTRL_T_N] && !$past(ext_t_n_i))
      else $error("carry low while trickle enable high");

   chk_carry_terminal: assert property (
      !carry_n_r |-> suc_terminal(cnt_r, up_eff))
      else $error("carry low away from terminal count");

   chk_carry_asserts: assert property (
      (suc_terminal(cnt_r, up_eff) && !ctrl_r[SUC_CTRL_T_N]
       && !$past(ext_t_n_i) && !$past(rst_i)) |-> !carry_n_r)
      else $error("carry missing at terminal count");

   chk_carry_pulse_up: assert property (
      (!carry_n_r && up_eff) |-> count_outputs_o[0])
      else $error("up carry low while bit0 low");

   chk_carry_one_cycle: assert property (
      (!carry_n_r && load_eff_n && !p_eff_n && !t_eff_n && !wr_ctrl)
      |=> carry_n_r)
      else $error("carry stayed low while counting on");

   chk_ctrl_on_edge: assert property (
      !wr_ctrl |=> $stable(ctrl_r))
      else $error("control changed without a write");

   chk_ack_single: assert property (
      ack_o |=> !ack_o)
      else $error("ack held longer than one cycle");

   cov_load: cover property (!load_eff_n ##1 cnt_r == 4'ha);
   cov_wrap_up: cover property (
      cnt_r == 4'hf && up_eff && !p_eff_n && !t_eff_n && load_eff_n
      ##1 cnt_r == 4'h0);
   cov_wrap_down: cover property (
      cnt_r == 4'h0 && !up_eff && !p_eff_n && !t_eff_n && load_eff_n
      ##1 cnt_r == 4'hf);
   cov_carry_low: cover property (!carry_n_r ##1 carry_n_r);

endmodule

// file: testbench/suc_stage_model.sv
// upstream cascade stage that drives the block's enable and load pins
// assumes the bench drives the mode inputs just after rising edges
`timescale 1ns/100ps
module suc_stage_model (
   input wire logic clk_i,    // shared clock
   input wire logic free_i,   // keeps both enables low unless hold_p_i or hold_t_i forces one high
   input wire logic hold_p_i, // forces enable p high
   input wire logic hold_t_i, // forces enable t high
   input wire logic load_i,   // asks for a load
   output logic p_n_o,        // to enable p, low
   output logic t_n_o,        // to enable t, low
   output logic load_n_o      // to load, low
);
   logic [3:0] stage_r = 4'h0;
   logic carry_n;
   // plain process: the declaration gives the start value, no reset pin here
   always @(posedge clk_i) begin
      stage_r <= stage_r + 4'h1;
   end
   // upstream carry at its terminal count feeds both enables
   assign carry_n = ~(free_i | (stage_r == 4'hf));
   assign p_n_o = hold_p_i | carry_n;
   assign t_n_o = hold_t_i | carry_n;
   assign load_n_o = ~load_i;
endmodule

// file: testbench/sync_updown_4bit_counter_test.sv
// self-checking bench for the counter top, with a reference model
// assumes the design package and a cascade stage model
`timescale 1ns/100ps
module sync_updown_4bit_counter_test;
   import suc_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [SUC_AW-1:0] adr_i = '0;
   logic [3:0] sel_i = 4'h0;
   logic [SUC_DW-1:0] dat_i = '0, dat_o;
   logic ack_o, carry_n_o, p_n, t_n, load_n;
   logic [SUC_CW-1:0] count_outputs_o;
   logic free = 1'b1, hold_p = 1'b0, hold_t = 1'b0, load = 1'b0;
   logic [7:0] mctrl = 8'h0e;
   logic [3:0] mcnt = 4'h0;
   logic mt_n = 1'b1;
   logic [3:0] v;
   int failures = 0, total_checks = 0, cycles = 0;
   initial begin
      forever #12.5 clk_i = ~clk_i;
   end
   suc_top u_suc_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ext_p_n_i(p_n),
      .ext_t_n_i(t_n), .ext_load_n_i(load_n), .dat_o(dat_o), .ack_o(ack_o),
      .count_outputs_o(count_outputs_o), .carry_n_o(carry_n_o));
   suc_stage_model u_suc_stage_model (.clk_i(clk_i), .free_i(free), .hold_p_i(hold_p),
      .hold_t_i(hold_t), .load_i(load), .p_n_o(p_n), .t_n_o(t_n), .load_n_o(load_n));
   // ****************************************
   // reference model and monitor
   // ****************************************
   always @(posedge clk_i) begin
      if (rst_i) begin
         mcnt = SUC_CNT_RST;
         mt_n = 1'b1;
      end else begin
         if (!mctrl[SUC_CTRL_LOAD_N] || !load_n) mcnt = mctrl[7:4];
         else if (!mctrl[SUC_CTRL_P_N] && !p_n && !mctrl[SUC_CTRL_T_N] && !t_n)
            mcnt = mctrl[SUC_CTRL_UP] ? mcnt + 4'h1 : mcnt - 4'h1;
         mt_n = t_n;
      end
   end
   always @(negedge clk_i) begin
      if (!rst_i) begin
         cmp_cnt(count_outputs_o, mcnt);
         cmp_bit(carry_n_o, ~(!mt_n && !mctrl[SUC_CTRL_T_N] &&
            (mctrl[SUC_CTRL_UP] ? mcnt == 4'hf : mcnt == 4'h0)));
      end
   end
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 2000) begin
         failures++;
         end_of_test();
      end
   end
   // ****************************************
   // compare and bus tasks
   // ****************************************
   task automatic bad(input logic [SUC_DW-1:0] got, input logic [SUC_DW-1:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_word(input logic [SUC_DW-1:0] got, input logic [SUC_DW-1:0] exp);
      bad(got, exp);
   endtask
   task automatic cmp_cnt(input logic [3:0] got, input logic [3:0] exp);
      bad({28'h0, got}, {28'h0, exp});
   endtask
   task automatic cmp_bit(input logic got, input logic exp);
      bad({31'h0, got}, {31'h0, exp});
   endtask
   task automatic bus(input logic wr, input logic [SUC_AW-1:0] a, input logic [3:0] s,
         input logic [SUC_DW-1:0] wd, output logic [SUC_DW-1:0] rd);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= wr;
      adr_i <= a;
      sel_i <= s;
      dat_i <= wd;
      // only the bench timeout ends a wait for ack
      do begin
         @(posedge clk_i);
      end while (ack_o !== 1'b1);
      rd = dat_o;
      if (wr && a == SUC_OFS_CTRL && s[0]) mctrl <= wd[7:0];
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
   endtask
   task automatic wr(input logic [SUC_AW-1:0] a, input logic [3:0] s, input logic [7:0] d);
      logic [SUC_DW-1:0] rd;
      bus(1'b1, a, s, {24'h0, d}, rd);
   endtask
   task automatic rd_chk(input logic [SUC_AW-1:0] a, input logic [SUC_DW-1:0] e);
      logic [SUC_DW-1:0] rd;
      bus(1'b0, a, 4'hf, '0, rd);
      cmp_word(rd, e);
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_regs();
      rd_chk(SUC_OFS_CTRL, 32'h0000_000e);
      rd_chk(SUC_OFS_STAT, 32'h0000_0010);
      wr(SUC_OFS_STAT, 4'hf, 8'h05);
      rd_chk(SUC_OFS_STAT, 32'h0000_0010);
      rd_chk(4'h8, 32'h0000_0000);
      wr(SUC_OFS_CTRL, 4'he, 8'h01);
      rd_chk(SUC_OFS_CTRL, 32'h0000_000e);
   endtask
   task automatic t_load_count();
      wr(SUC_OFS_CTRL, 4'h1, 8'he6);
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      cmp_cnt(count_outputs_o, 4'he);
      rd_chk(SUC_OFS_STAT, 32'h0000_001e);
      // load off, both enables low: up through the wrap, then down
      wr(SUC_OFS_CTRL, 4'h1, 8'he9);
      repeat (20) @(posedge clk_i);
      wr(SUC_OFS_CTRL, 4'h1, 8'h08);
      repeat (20) @(posedge clk_i);
   endtask
   task automatic t_hold();
      // park the count at the down terminal value with p held off
      hold_p <= 1'b1;
      wr(SUC_OFS_CTRL, 4'h1, 8'h00);
      wr(SUC_OFS_CTRL, 4'h1, 8'h08);
      @(negedge clk_i);
      v = count_outputs_o;
      repeat (5) @(negedge clk_i);
      cmp_cnt(count_outputs_o, v);
      cmp_cnt(count_outputs_o, 4'h0);
      cmp_bit(carry_n_o, 1'b0);
      @(posedge clk_i);
      hold_p <= 1'b0;
      hold_t <= 1'b1;
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      cmp_bit(carry_n_o, 1'b1);
      @(posedge clk_i);
      hold_t <= 1'b0;
   endtask
   task automatic t_cascade();
      wr(SUC_OFS_CTRL, 4'h1, 8'h09);
      free <= 1'b0;
      repeat (40) @(posedge clk_i);
      free <= 1'b1;
   endtask
   task automatic t_ext_load();
      // register load stays off, so only the pin can load
      wr(SUC_OFS_CTRL, 4'h1, 8'ha9);
      load <= 1'b1;
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      cmp_cnt(count_outputs_o, 4'ha);
      @(posedge clk_i);
      load <= 1'b0;
      repeat (10) @(posedge clk_i);
   endtask
   task automatic end_of_test();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_regs();
      t_load_count();
      t_hold();
      t_cascade();
      t_ext_load();
      end_of_test();
   end
endmodule
